// ==== hdl/video_filter_regs_defs.svh ====
`ifndef VIDEO_FILTER_REGS_DEFS_SVH
`define VIDEO_FILTER_REGS_DEFS_SVH

// Register offsets (byte addresses, low 12 bits decoded)
`define OFS_CORE_CONTROL     12'h000
`define OFS_EVENT_FLAGS      12'h004
`define OFS_FRAMING_ERRORS   12'h008
`define OFS_INTERRUPT_MASK   12'h00C
`define OFS_HW_REVISION      12'h010
`define OFS_FRAMES_DONE      12'h014
`define OFS_LINES_DONE       12'h018
`define OFS_PIXELS_DONE      12'h01C
`define OFS_FRAME_DIMENSIONS 12'h020
`define OFS_BLUR_THRESHOLD   12'h100
`define OFS_SHARPEN_GAIN     12'h104
`define OFS_OVERSHOOT_GAIN   12'h108

// Control register bit positions
`define CTRL_ENABLE_BIT      0
`define CTRL_COMMIT_BIT      1
`define CTRL_FRAME_RST_BIT   30
`define CTRL_SOFT_RST_BIT    31

// Event flag bit positions
`define EVT_FRAME_BEGUN_BIT  0
`define EVT_FRAME_DONE_BIT   1
`define EVT_FRAMING_ERR_BIT  16

// Framing error bit positions
`define ERR_LINE_SHORT_BIT   0
`define ERR_LINE_LONG_BIT    1
`define ERR_FRAME_SHORT_BIT  2
`define ERR_FRAME_LONG_BIT   3

// Frame dimension field positions
`define DIM_PIXELS_LSB       0
`define DIM_PIXELS_MSB       12
`define DIM_LINES_LSB        16
`define DIM_LINES_MSB        28

// Values
`define GAIN_UNITY           16'h8000
`define MASK_IMPL_BITS       32'h0001_FFFF
`define HW_REVISION_VALUE    32'h0800_0000
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ==== hdl/video_filter_pkg.sv ====
package video_filter_pkg;

  // Observed stream beat
  typedef struct packed {
    logic valid;
    logic ready;
    logic sof;
    logic eol;
  } stream_mon_t;

  // Active filter configuration
  typedef struct packed {
    logic [12:0] pixels;
    logic [12:0] lines;
    logic [15:0] blurThreshold;
    logic [15:0] sharpenGain;
    logic [15:0] overshootGain;
  } filter_cfg_t;

  // Frame tracker states (Gray coded)
  typedef enum logic [0:0] {
    FRAME_IDLE   = 1'b0,
    FRAME_ACTIVE = 1'b1
  } frame_state_t;

endpackage

// ==== hdl/video_filter_control_status_regs.sv ====
`timescale 1ns/100ps
`include "video_filter_regs_defs.svh"
module video_filter_control_status_regs #(
  parameter int          DATA_WIDTH   = 8,
  parameter int          MAX_PIXELS   = 1920,
  parameter bit          HAS_REG_PORT = 1'b1,
  parameter logic [12:0] DEF_PIXELS   = 13'd1920,
  parameter logic [12:0] DEF_LINES    = 13'd1080,
  parameter logic [15:0] DEF_BLUR     = 16'h0010,
  parameter logic [15:0] DEF_SHARPEN  = 16'h4000,
  parameter logic [15:0] DEF_OVERSHT  = 16'h4000
) (
  input  wire logic                        core_clk,       // Core clock, 20 MHz
  input  wire logic                        rst,            // Async reset, active high
  input  wire logic                        s_axi_aresetn,  // Bus reset, sync, active low
  input  wire logic [31:0]                 s_axi_awaddr,   // Write address
  input  wire logic                        s_axi_awvalid,  // Write address valid
  output logic                             s_axi_awready,  // Write address ready
  input  wire logic [31:0]                 s_axi_wdata,    // Write data
  input  wire logic [3:0]                  s_axi_wstrb,    // Write byte strobes
  input  wire logic                        s_axi_wvalid,   // Write data valid
  output logic                             s_axi_wready,   // Write data ready
  output logic [1:0]                       s_axi_bresp,    // Write response
  output logic                             s_axi_bvalid,   // Write response valid
  input  wire logic                        s_axi_bready,   // Write response ready
  input  wire logic [31:0]                 s_axi_araddr,   // Read address
  input  wire logic                        s_axi_arvalid,  // Read address valid
  output logic                             s_axi_arready,  // Read address ready
  output logic [31:0]                      s_axi_rdata,    // Read data
  output logic [1:0]                       s_axi_rresp,    // Read response
  output logic                             s_axi_rvalid,   // Read data valid
  input  wire logic                        s_axi_rready,   // Read data ready
  input  wire video_filter_pkg::stream_mon_t streamIn,     // Observed input stream beat
  output logic                             irq,            // Level interrupt
  output logic [8:0]                       parallelEventVector, // Unheld event vector
  output video_filter_pkg::filter_cfg_t    activeCfg,      // Active configuration set
  output logic                             swEnable,       // Software enable bit
  output logic                             coreResetOut    // Datapath reset request
);
  import video_filter_pkg::*;

  // Parameter range checks
  if (DATA_WIDTH < 1 || DATA_WIDTH > 16) begin : gChkWidth
    $error("DATA_WIDTH must be 1 to 16");
  end
  if (MAX_PIXELS < 32 || MAX_PIXELS > 8191) begin : gChkPixels
    $error("MAX_PIXELS must be 32 to 8191");
  end

  localparam logic [15:0] THRESH_MASK = 16'((32'd1 << DATA_WIDTH) - 32'd1);

  // Register state
  logic [31:0]  control_reg;
  logic [31:0]  eventFlags_reg;
  logic [3:0]   errorFlags_reg;
  logic [16:0]  irqMask_reg;
  logic [31:0]  framesDone_reg;
  logic [31:0]  linesDone_reg;
  logic [31:0]  pixelsDone_reg;
  filter_cfg_t  shadowCfg_reg;
  filter_cfg_t  activeCfg_reg;
  logic         bvalid_reg;
  logic         rvalid_reg;
  logic [31:0]  rdata_reg;
  logic [1:0]   rresp_reg;
  logic [1:0]   bresp_reg;
  logic         irq_reg;
  logic [8:0]   eventVec_reg;
  logic         coreReset_reg;
  frame_state_t frameState_reg;
  logic [13:0]  linePix_reg;
  logic [12:0]  lineIdx_reg;
  logic [26:0]  framePix_reg;

  // Bus handshake
  logic        wrFire;
  logic        rdFire;
  logic [11:0] wrAddr;
  logic [11:0] rdAddr;
  logic [31:0] byteMask;
  logic        busReset;

  assign wrFire        = s_axi_awvalid & s_axi_wvalid & ~bvalid_reg;
  assign rdFire        = s_axi_arvalid & ~rvalid_reg;
  assign s_axi_awready = wrFire;
  assign s_axi_wready  = wrFire;
  assign s_axi_arready = ~rvalid_reg;
  assign wrAddr        = {s_axi_awaddr[11:2], 2'b00};
  assign rdAddr        = {s_axi_araddr[11:2], 2'b00};
  assign busReset      = ~s_axi_aresetn;

  // Byte lane mask from strobes
  genvar gb;
  for (gb = 0; gb < 4; gb++) begin : gLanes
    assign byteMask[gb*8 +: 8] = {8{s_axi_wstrb[gb]}};
  end

  // Write data merged into a register under strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] mask, input logic [31:0] data);
    merge = (old & ~mask) | (data & mask);
  endfunction

  // Write decode
  logic wrCtrl;
  logic wrEvt;
  logic wrErr;
  logic wrMask;
  logic wrDims;
  logic wrBlur;
  logic wrSharp;
  logic wrOver;
  assign wrCtrl  = wrFire && wrAddr == `OFS_CORE_CONTROL;
  assign wrEvt   = wrFire && wrAddr == `OFS_EVENT_FLAGS;
  assign wrErr   = wrFire && wrAddr == `OFS_FRAMING_ERRORS;
  assign wrMask  = wrFire && wrAddr == `OFS_INTERRUPT_MASK;
  assign wrDims  = wrFire && wrAddr == `OFS_FRAME_DIMENSIONS;
  assign wrBlur  = wrFire && wrAddr == `OFS_BLUR_THRESHOLD;
  assign wrSharp = wrFire && wrAddr == `OFS_SHARPEN_GAIN;
  assign wrOver  = wrFire && wrAddr == `OFS_OVERSHOOT_GAIN;

  // Stream framing checks
  logic        beat;
  logic        beatInFrame;
  logic [13:0] lpNow;
  logic [26:0] fpNow;
  logic [26:0] frameTotal;
  logic        lineShort;
  logic        lineLong;
  logic        frameShort;
  logic        frameLong;
  logic        frameBegin;
  logic        frameEnd;
  logic        anyError;
  logic        frameRstDo;
  logic        clearAll;

  assign beat        = streamIn.valid & streamIn.ready;
  assign beatInFrame = beat & (streamIn.sof | frameState_reg == FRAME_ACTIVE);
  assign frameTotal  = 27'(activeCfg_reg.pixels * activeCfg_reg.lines);
  assign lpNow       = streamIn.sof ? 14'd1 : (&linePix_reg ? linePix_reg : linePix_reg + 14'd1);
  assign fpNow       = streamIn.sof ? 27'd1 : (&framePix_reg ? framePix_reg : framePix_reg + 27'd1);
  assign frameBegin  = beat & streamIn.sof;
  assign lineShort   = beatInFrame & streamIn.eol & (lpNow < {1'b0, activeCfg_reg.pixels});
  assign lineLong    = beatInFrame & ~streamIn.eol & (lpNow == {1'b0, activeCfg_reg.pixels} + 14'd1);
  assign frameShort  = frameBegin & (frameState_reg == FRAME_ACTIVE) & (framePix_reg < frameTotal);
  assign frameLong   = beatInFrame & ~streamIn.sof & (fpNow == frameTotal + 27'd1);
  assign frameEnd    = beatInFrame & streamIn.eol
                       & ((streamIn.sof ? 13'd0 : lineIdx_reg) == activeCfg_reg.lines - 13'd1);
  assign anyError    = lineShort | lineLong | frameShort | frameLong;

  // Frame-aligned reset fires between frames or at frame end
  assign frameRstDo  = control_reg[`CTRL_FRAME_RST_BIT]
                       & (frameState_reg == FRAME_IDLE | frameEnd);
  assign clearAll    = HAS_REG_PORT & (control_reg[`CTRL_SOFT_RST_BIT] | frameRstDo);

  // Control register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      control_reg <= 32'h0000_0000;
    end else if (busReset) begin
      control_reg <= 32'h0000_0000;
    end else begin
      logic [31:0] ctrlNext;
      ctrlNext = control_reg;
      if (clearAll) begin
        ctrlNext = control_reg & (32'h1 << `CTRL_SOFT_RST_BIT);
      end
      if (wrCtrl) begin
        ctrlNext = merge(control_reg, byteMask, s_axi_wdata);
      end else if (frameRstDo) begin
        ctrlNext[`CTRL_FRAME_RST_BIT] = 1'b0;
      end
      control_reg <= ctrlNext & 32'hC000_0003;
    end
  end

  // Event flags: set wins over write-one clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eventFlags_reg <= 32'h0000_0000;
    end else if (busReset || clearAll) begin
      eventFlags_reg <= 32'h0000_0000;
    end else begin
      logic [31:0] evtSet;
      evtSet = 32'h0000_0000;
      evtSet[`EVT_FRAME_BEGUN_BIT] = frameBegin;
      evtSet[`EVT_FRAME_DONE_BIT]  = frameEnd;
      evtSet[`EVT_FRAMING_ERR_BIT] = anyError;
      eventFlags_reg <= (eventFlags_reg & ~(wrEvt ? (s_axi_wdata & byteMask) : 32'h0)) | evtSet;
    end
  end

  // Framing error flags, one per bit
  logic [3:0] errSet;
  assign errSet[`ERR_LINE_SHORT_BIT]  = lineShort;
  assign errSet[`ERR_LINE_LONG_BIT]   = lineLong;
  assign errSet[`ERR_FRAME_SHORT_BIT] = frameShort;
  assign errSet[`ERR_FRAME_LONG_BIT]  = frameLong;
  genvar ge;
  for (ge = 0; ge < 4; ge++) begin : gErr
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        errorFlags_reg[ge] <= 1'b0;
      end else if (busReset || clearAll) begin
        errorFlags_reg[ge] <= 1'b0;
      end else if (errSet[ge]) begin
        errorFlags_reg[ge] <= 1'b1;
      end else if (wrErr && s_axi_wstrb[0] && s_axi_wdata[ge]) begin
        errorFlags_reg[ge] <= 1'b0;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irqMask_reg <= 17'h0_0000;
    end else if (busReset || clearAll) begin
      irqMask_reg <= 17'h0_0000;
    end else if (wrMask) begin
      irqMask_reg <= 17'(merge({15'h0, irqMask_reg}, byteMask, s_axi_wdata));
    end
  end

  // Level interrupt from masked flags
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else if (busReset || clearAll) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= HAS_REG_PORT & (|(eventFlags_reg[16:0] & irqMask_reg));
    end
  end

  // Throughput counters
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      framesDone_reg <= 32'h0000_0000;
      linesDone_reg  <= 32'h0000_0000;
      pixelsDone_reg <= 32'h0000_0000;
    end else if (busReset || clearAll) begin
      framesDone_reg <= 32'h0000_0000;
      linesDone_reg  <= 32'h0000_0000;
      pixelsDone_reg <= 32'h0000_0000;
    end else begin
      framesDone_reg <= framesDone_reg + 32'(frameEnd);
      linesDone_reg  <= linesDone_reg + 32'(beatInFrame & streamIn.eol);
      pixelsDone_reg <= pixelsDone_reg + 32'(beatInFrame);
    end
  end

  // Frame tracker
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frameState_reg <= FRAME_IDLE;
      linePix_reg    <= 14'h0000;
      lineIdx_reg    <= 13'h0000;
      framePix_reg   <= 27'h000_0000;
    end else if (busReset || clearAll) begin
      frameState_reg <= FRAME_IDLE;
      linePix_reg    <= 14'h0000;
      lineIdx_reg    <= 13'h0000;
      framePix_reg   <= 27'h000_0000;
    end else if (beatInFrame) begin
      framePix_reg <= fpNow;
      linePix_reg  <= streamIn.eol ? 14'h0000 : lpNow;
      if (frameEnd) begin
        frameState_reg <= FRAME_IDLE;
        lineIdx_reg    <= 13'h0000;
      end else begin
        frameState_reg <= FRAME_ACTIVE;
        if (streamIn.eol) begin
          lineIdx_reg <= (streamIn.sof ? 13'd0 : lineIdx_reg) + 13'd1;
        end else if (streamIn.sof) begin
          lineIdx_reg <= 13'h0000;
        end
      end
    end
  end

  // Shadow configuration written by software
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shadowCfg_reg <= '{DEF_PIXELS, DEF_LINES, DEF_BLUR & THRESH_MASK, DEF_SHARPEN, DEF_OVERSHT};
    end else if (busReset || clearAll) begin
      shadowCfg_reg <= '{DEF_PIXELS, DEF_LINES, DEF_BLUR & THRESH_MASK, DEF_SHARPEN, DEF_OVERSHT};
    end else begin
      logic [31:0] w;
      w = 32'h0000_0000;
      if (wrDims) begin
        w = merge({3'h0, shadowCfg_reg.lines, 3'h0, shadowCfg_reg.pixels}, byteMask, s_axi_wdata);
        shadowCfg_reg.pixels <= w[`DIM_PIXELS_MSB:`DIM_PIXELS_LSB];
        shadowCfg_reg.lines  <= w[`DIM_LINES_MSB:`DIM_LINES_LSB];
      end
      if (wrBlur) begin
        w = merge({16'h0, shadowCfg_reg.blurThreshold}, byteMask, s_axi_wdata);
        shadowCfg_reg.blurThreshold <= w[15:0] & THRESH_MASK;
      end
      if (wrSharp) begin
        w = merge({16'h0, shadowCfg_reg.sharpenGain}, byteMask, s_axi_wdata);
        shadowCfg_reg.sharpenGain <= (w[15:0] > `GAIN_UNITY) ? `GAIN_UNITY : w[15:0];
      end
      if (wrOver) begin
        w = merge({16'h0, shadowCfg_reg.overshootGain}, byteMask, s_axi_wdata);
        shadowCfg_reg.overshootGain <= (w[15:0] > `GAIN_UNITY) ? `GAIN_UNITY : w[15:0];
      end
    end
  end

  // Active configuration, copied at frame end when commit is set
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      activeCfg_reg <= '{DEF_PIXELS, DEF_LINES, DEF_BLUR & THRESH_MASK, DEF_SHARPEN, DEF_OVERSHT};
    end else if (busReset || clearAll) begin
      activeCfg_reg <= '{DEF_PIXELS, DEF_LINES, DEF_BLUR & THRESH_MASK, DEF_SHARPEN, DEF_OVERSHT};
    end else if (frameEnd && control_reg[`CTRL_COMMIT_BIT]) begin
      activeCfg_reg <= shadowCfg_reg;
    end
  end

  // Unheld event vector, one cycle per event
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eventVec_reg <= 9'h000;
    end else if (busReset || clearAll) begin
      eventVec_reg <= 9'h000;
    end else begin
      eventVec_reg <= {frameLong, frameShort, lineLong, lineShort, anyError, frameEnd,
                       beatInFrame & (lpNow == {1'b0, activeCfg_reg.pixels}),
                       frameEnd, frameBegin};
    end
  end

  // Datapath reset request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      coreReset_reg <= 1'b0;
    end else begin
      coreReset_reg <= busReset | clearAll;
    end
  end

  // Write response
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (busReset) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `RESP_OKAY;
    end else if (wrFire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wrCtrl | wrEvt | wrErr | wrMask | wrDims | wrBlur | wrSharp | wrOver)
                    ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Read data path
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `RESP_OKAY;
    end else if (busReset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `RESP_OKAY;
    end else if (rdFire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `RESP_OKAY;
      unique case (rdAddr)
        `OFS_CORE_CONTROL:     rdata_reg <= control_reg;
        `OFS_EVENT_FLAGS:      rdata_reg <= eventFlags_reg;
        `OFS_FRAMING_ERRORS:   rdata_reg <= {28'h0, errorFlags_reg};
        `OFS_INTERRUPT_MASK:   rdata_reg <= {15'h0, irqMask_reg};
        `OFS_HW_REVISION:      rdata_reg <= `HW_REVISION_VALUE;
        `OFS_FRAMES_DONE:      rdata_reg <= framesDone_reg;
        `OFS_LINES_DONE:       rdata_reg <= linesDone_reg;
        `OFS_PIXELS_DONE:      rdata_reg <= pixelsDone_reg;
        `OFS_FRAME_DIMENSIONS: rdata_reg <= {3'h0, shadowCfg_reg.lines, 3'h0, shadowCfg_reg.pixels};
        `OFS_BLUR_THRESHOLD:   rdata_reg <= {16'h0, shadowCfg_reg.blurThreshold};
        `OFS_SHARPEN_GAIN:     rdata_reg <= {16'h0, shadowCfg_reg.sharpenGain};
        `OFS_OVERSHOOT_GAIN:   rdata_reg <= {16'h0, shadowCfg_reg.overshootGain};
        default: begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Outputs
  assign s_axi_bvalid        = bvalid_reg;
  assign s_axi_bresp         = bresp_reg;
  assign s_axi_rvalid        = rvalid_reg;
  assign s_axi_rdata         = rdata_reg;
  assign s_axi_rresp         = rresp_reg;
  assign irq                 = irq_reg;
  assign parallelEventVector = eventVec_reg;
  assign activeCfg           = activeCfg_reg;
  assign swEnable            = control_reg[`CTRL_ENABLE_BIT];
  assign coreResetOut        = coreReset_reg;

endmodule

// ==== dv/video_filter_regs_props.sv ====
`timescale 1ns/100ps
module status_regs_props (
  input wire logic                          core_clk,            // Core clock
  input wire logic                          rst,                 // Async reset
  input wire logic                          s_axi_aresetn,       // Bus reset, low
  input wire logic                          s_axi_awvalid,       // Write address valid
  input wire logic                          s_axi_wvalid,        // Write data valid
  input wire logic                          s_axi_bvalid,        // Write response valid
  input wire logic                          s_axi_arvalid,       // Read address valid
  input wire logic                          s_axi_arready,       // Read address ready
  input wire logic                          s_axi_rvalid,        // Read data valid
  input wire video_filter_pkg::stream_mon_t streamIn,            // Observed beat
  input wire logic                          irq,                 // Level interrupt
  input wire logic [8:0]                    parallelEventVector, // Unheld events
  input wire logic                          coreResetOut         // Datapath reset
);
  import video_filter_pkg::*;
  logic beat;
  // Stream beat as the design samples it
  assign beat = streamIn.valid && streamIn.ready;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Write taken while the bus is out of reset
  sequence wr_take_s;
    s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_aresetn;
  endsequence
  // Bus reset followed by the datapath reset request
  sequence bus_rst_s;
    !s_axi_aresetn ##1 coreResetOut && !s_axi_bvalid && !s_axi_rvalid;
  endsequence
  write_answer_a: assert property (wr_take_s |=> s_axi_bvalid)
    else $error("write response missing");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_aresetn |=> s_axi_rvalid)
    else $error("read data missing");
  frame_begin_a: assert property (parallelEventVector[0] |-> $past(beat && streamIn.sof))
    else $error("frame start without start beat");
  frame_done_a: assert property (parallelEventVector[1] |-> $past(beat && streamIn.eol))
    else $error("frame done without line end beat");
  error_any_a: assert property (parallelEventVector[4] == (|parallelEventVector[8:5]))
    else $error("error summary disagrees");
  line_short_a: assert property (parallelEventVector[5] |-> $past(beat && streamIn.eol))
    else $error("short line without line end");
  line_long_a: assert property (parallelEventVector[6] |-> $past(beat && !streamIn.eol))
    else $error("long line on a line end");
  frame_short_a: assert property (parallelEventVector[7] |-> $past(beat && streamIn.sof))
    else $error("short frame without start beat");
  frame_long_a: assert property (parallelEventVector[8] |-> $past(beat && !streamIn.sof))
    else $error("long frame on a start beat");
  irq_level_a: assert property (irq && !$past(s_axi_awvalid && s_axi_wvalid) |=> irq || coreResetOut)
    else $error("interrupt dropped without clear");
  reset_quiet_a: assert property (coreResetOut |-> !irq)
    else $error("interrupt during reset");
  bus_reset_a: assert property (!s_axi_aresetn |-> bus_rst_s)
    else $error("bus reset not honoured");
endmodule
bind video_filter_control_status_regs status_regs_props i_props (.core_clk, .rst, .s_axi_aresetn,
  .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .streamIn, .irq, .parallelEventVector, .coreResetOut);

// ==== dv/stream_source.sv ====
`timescale 1ns/100ps
module stream_source (
  input  wire logic                   core_clk, // Stream clock
  output video_filter_pkg::stream_mon_t beat    // Beat seen by the monitor
);
  import video_filter_pkg::*;
  initial beat = '0;
  // Send n beats, start marker on the first if s, line end on beat e; sink stalls at random
  task automatic line(input int n, input bit s, input int e);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      beat.valid = 1'b1;
      beat.ready = ($urandom % 4) != 0;
      beat.sof = s && (i == 0);
      beat.eol = (i + 1) == e;
      while (!beat.ready) begin
        @(negedge core_clk);
        beat.ready = 1'b1;
      end
    end
    // Idle: markers no longer hold their last value
    @(negedge core_clk);
    beat.valid = 1'b0;
    beat.sof = ~beat.sof;
    beat.eol = ~beat.eol;
  endtask
endmodule

// ==== dv/test_video_filter_control_status_regs.sv ====
`timescale 1ns/100ps
`include "video_filter_regs_defs.svh"
module test_video_filter_control_status_regs;
  import video_filter_pkg::*;
  logic core_clk, rst, s_axi_aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [8:0]  parallelEventVector;
  logic        coreResetOut;
  stream_mon_t streamIn;
  filter_cfg_t cfg;
  int          failures = 0;
  int          totalChecks = 0;
  video_filter_control_status_regs #(.DEF_PIXELS(13'd4), .DEF_LINES(13'd2)) i_dut (.core_clk, .rst,
    .s_axi_aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .streamIn, .irq, .parallelEventVector, .activeCfg(cfg), .swEnable(), .coreResetOut);
  stream_source i_src (.core_clk(core_clk), .beat(streamIn));
  // Clock, 50 ns period
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  function automatic logic [31:0] dims(input logic [12:0] p, input logic [12:0] l);
    return {3'h0, l, 3'h0, p};
  endfunction
  function automatic logic [15:0] clampGain(input logic [15:0] g);
    return (g > `GAIN_UNITY) ? `GAIN_UNITY : g;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    totalChecks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    if (failures == 0 && totalChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Register write
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge core_clk);
    s_axi_awaddr = {20'h0, a};
    s_axi_wdata = d;
    {s_axi_awvalid, s_axi_wvalid} = 2'b11;
    do @(posedge core_clk); while (s_axi_awready !== 1'b1);
    @(negedge core_clk);
    {s_axi_awvalid, s_axi_wvalid} = 2'b00;
    while (s_axi_bvalid !== 1'b1) @(negedge core_clk);
    chk("bresp", 32'(s_axi_bresp), 32'(`RESP_OKAY));
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(negedge core_clk);
    s_axi_araddr = {20'h0, a};
    s_axi_arvalid = 1'b1;
    while (s_axi_arready !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    s_axi_arvalid = 1'b0;
    while (s_axi_rvalid !== 1'b1) @(negedge core_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk($sformatf("reg_%h", a), d, e);
  endtask
  // Hang guard
  initial begin
    #400_000;
    failures++;
    end_of_test;
  end
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    logic [12:0] p;
    logic [12:0] l;
    logic [15:0] gains [4];
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    rst = 1'b1;
    s_axi_aresetn = 1'b1;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    s_axi_wstrb = 4'hF;
    v = $urandom(32'h0000_668a);
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    // Reset values and an unmapped place
    rc(`OFS_HW_REVISION, `HW_REVISION_VALUE);
    rc(`OFS_EVENT_FLAGS, 32'h0);
    rd(12'h030, v, r);
    chk("unmapped_resp", {30'h0, r}, {30'h0, `RESP_SLVERR});
    chk("unmapped_data", v, 32'h0);
    // One clean frame of two lines
    i_src.line(4, 1'b1, 4);
    i_src.line(4, 1'b0, 4);
    rc(`OFS_EVENT_FLAGS, 32'h0000_0003);
    rc(`OFS_FRAMING_ERRORS, 32'h0);
    rc(`OFS_FRAMES_DONE, 32'h1);
    rc(`OFS_LINES_DONE, 32'h2);
    rc(`OFS_PIXELS_DONE, 32'h8);
    wr(`OFS_EVENT_FLAGS, 32'h0000_0001);
    wr(`OFS_EVENT_FLAGS, 32'h0);
    rc(`OFS_EVENT_FLAGS, 32'h0000_0002);
    // Mask readback, interrupt raised then cleared
    v = $urandom;
    wr(`OFS_INTERRUPT_MASK, v);
    rc(`OFS_INTERRUPT_MASK, v & `MASK_IMPL_BITS);
    wr(`OFS_INTERRUPT_MASK, 32'h2);
    repeat (2) @(negedge core_clk);
    chk("irq_set", {31'h0, irq}, 32'h1);
    wr(`OFS_EVENT_FLAGS, 32'h2);
    repeat (2) @(negedge core_clk);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    // Short line, short frame, then long line and long frame
    i_src.line(2, 1'b1, 2);
    i_src.line(1, 1'b1, 0);
    i_src.line(9, 1'b0, 0);
    rc(`OFS_FRAMING_ERRORS, 32'hF);
    rd(`OFS_EVENT_FLAGS, v, r);
    chk("error_flag", v & 32'h0001_0000, 32'h0001_0000);
    // Immediate soft reset
    wr(`OFS_CORE_CONTROL, 32'h8000_0000);
    rc(`OFS_EVENT_FLAGS, 32'h0);
    rc(`OFS_FRAMING_ERRORS, 32'h0);
    rc(`OFS_INTERRUPT_MASK, 32'h0);
    rc(`OFS_FRAMES_DONE, 32'h0);
    wr(`OFS_CORE_CONTROL, 32'h0);
    // Frame-aligned reset, idle then mid-frame
    wr(`OFS_CORE_CONTROL, 32'h4000_0000);
    rc(`OFS_CORE_CONTROL, 32'h0);
    i_src.line(4, 1'b1, 4);
    wr(`OFS_CORE_CONTROL, 32'h4000_0000);
    rc(`OFS_CORE_CONTROL, 32'h4000_0000);
    i_src.line(4, 1'b0, 4);
    rc(`OFS_CORE_CONTROL, 32'h0);
    // Dimensions within the supported range, gains at and past unity
    p = 13'd32 + 13'($urandom % 1889);
    l = 13'd32 + 13'($urandom % 7649);
    wr(`OFS_FRAME_DIMENSIONS, dims(p, l));
    rc(`OFS_FRAME_DIMENSIONS, dims(p, l));
    chk("cfg_held", 32'(cfg.pixels), 32'd4);
    gains = '{16'hFFFF, 16'h8000, 16'h8001, 16'h0000};
    gains[3] = 16'($urandom);
    foreach (gains[i]) begin
      wr(`OFS_SHARPEN_GAIN, {16'h0, gains[i]});
      wr(`OFS_OVERSHOOT_GAIN, {16'h0, ~gains[i]});
      rc(`OFS_SHARPEN_GAIN, {16'h0, clampGain(gains[i])});
      rc(`OFS_OVERSHOOT_GAIN, {16'h0, clampGain(~gains[i])});
    end
    wr(`OFS_BLUR_THRESHOLD, 32'h0000_01FF);
    rc(`OFS_BLUR_THRESHOLD, 32'h0000_00FF);
    wr(`OFS_CORE_CONTROL, 32'h2);
    i_src.line(4, 1'b1, 4);
    i_src.line(4, 1'b0, 4);
    chk("cfg_taken", dims(cfg.pixels, cfg.lines), dims(p, l));
    // Bus reset
    wr(`OFS_INTERRUPT_MASK, `MASK_IMPL_BITS);
    s_axi_aresetn = 1'b0;
    repeat (32) @(negedge core_clk);
    s_axi_aresetn = 1'b1;
    rc(`OFS_INTERRUPT_MASK, 32'h0);
    end_of_test;
  end
endmodule
